// *** rtl/rxcru_consts.svh ***
// Purpose: offsets, field positions, reset values and write masks of the receive line registers
// Assumes: 8-bit register address, 16-bit register data
// Notes:   definitions only, included by the register bank and the loss-of-signal detector
`ifndef RXCRU_CONSTS_SVH
`define RXCRU_CONSTS_SVH

// register offsets
`define RXCRU_OFS_LOCK_SOURCE_STATUS     8'h23
`define RXCRU_OFS_QGEN      8'h30
`define RXCRU_OFS_QSYNTH    8'h31
`define RXCRU_OFS_QIRQEN    8'h33
`define RXCRU_OFS_QEVENT    8'h34

// training config/status fields
`define RXCRU_LOSCNT_HI     15
`define RXCRU_LOSCNT_LO     11
`define RXCRU_LOSEN_BIT     10
`define RXCRU_LLOOP_BIT     9
`define RXCRU_SDINV_BIT     8
`define RXCRU_RXINV_BIT     7
`define RXCRU_DUNLK_BIT     6
`define RXCRU_RUNLK_BIT     5
`define RXCRU_LOCK_SOURCE_STATUS_BIT     4
`define RXCRU_LOCK_SOURCE_STATUS_RST     16'h440F
`define RXCRU_LOCK_SOURCE_STATUS_WMASK   16'hFF8F

// quad general control fields
`define RXCRU_IREF_BIT      4
`define RXCRU_REFMODE_BIT   2
`define RXCRU_QDIS_BIT      0
`define RXCRU_QGEN_RST      16'h0030
`define RXCRU_QGEN_WMASK    16'h003F

// quad synthesizer control fields
`define RXCRU_SRSTN_BIT     0
`define RXCRU_QSYNTH_RST    16'h4A1F
`define RXCRU_QSYNTH_WMASK  16'hFFFF

// quad interrupt enable fields
`define RXCRU_MRDIS_BIT     4
`define RXCRU_SRDIS_BIT     3
`define RXCRU_SRLIVE_BIT    9
`define RXCRU_QIRQEN_RST    16'h0000
`define RXCRU_QIRQEN_WMASK  16'h001F

// event flag count (lock, slave runaway, master runaway) and loss-of-signal unit shift, 16 bits
`define RXCRU_EVT_COUNT     3
`define RXCRU_LOS_UNIT      4

`endif

// *** rtl/rxcru_pkg.sv ***
// Purpose: shared types of the receive line register bank
// Assumes: nothing beyond the consts header
// Notes:   types only; numbers live in rxcru_consts.svh
package rxcru_pkg;

    // recovery loop lock source
    typedef enum logic [0:0] {
        RXCRU_LOCK_REF  = 1'b0,  // training on reference clock
        RXCRU_LOCK_DATA = 1'b1   // tracking received data
    } rxcru_lock_state_t;

    // timing source of the receive FIFO output
    typedef enum logic [1:0] {
        RXCRU_FCLK_SYNTH = 2'b00,  // receive synthesizer clock
        RXCRU_FCLK_RECOV = 2'b01,  // recovered clock
        RXCRU_FCLK_TX    = 2'b10   // transmitter clock, line loopback
    } rxcru_fifo_clk_t;

endpackage

// *** rtl/rxcru_los_detect.sv ***
// Purpose: loss-of-signal detector on runs of identical received bits
// Assumes: one received bit per clock, signal detect already polarity corrected
// Notes:   run length saturates, so a dead line stays flagged indefinitely
`timescale 1ns/1ps
`default_nettype none
`include "rxcru_consts.svh"

module rxcru_los_detect #(
    parameter int CNT_W = 5   // width of the programmed run count
) (
    input  wire logic             clock,      // system clock
    input  wire logic             sys_rst,    // synchronous reset, high
    input  wire logic             dataBit,    // received bit after inversion
    input  wire logic             losEnable,  // transition detector on
    input  wire logic [CNT_W-1:0] losCount,   // run length in units of 16 bits
    input  wire logic             sigDetect,  // internal signal detect, high = present
    output logic                  losEvent    // loss-of-signal indication
);
    localparam int RUN_W = CNT_W + `RXCRU_LOS_UNIT + 1;

    // count scaled to bits, each unit is sixteen bits
    function automatic logic [RUN_W-1:0] runLimit(input logic [CNT_W-1:0] cnt);
        runLimit = {1'b0, cnt, {`RXCRU_LOS_UNIT{1'b0}}};
    endfunction

    logic             prevBit_r;   // last received bit
    logic [RUN_W-1:0] runLen_r;    // identical bits seen so far
    logic [RUN_W-1:0] runLen_nxt;  // next run length
    logic             runHit;      // run reached the programmed length

    // restart on a transition, saturate at the top
    assign runLen_nxt = (dataBit != prevBit_r) ? {{(RUN_W-1){1'b0}}, 1'b1} :
                        (&runLen_r) ? runLen_r : runLen_r + 1'b1;
    assign runHit     = losEnable && (runLen_r >= runLimit(losCount));

    // run counter cleared while the detector is off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prevBit_r <= 1'b0;
            runLen_r  <= '0;
        end else if (losEnable) begin
            prevBit_r <= dataBit;
            runLen_r  <= runLen_nxt;
        end else begin
            prevBit_r <= dataBit;
            runLen_r  <= '0;
        end
    end

    // missing signal detect or a long run both mean loss
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            losEvent <= 1'b0;
        end else begin
            losEvent <= !sigDetect || runHit;
        end
    end

endmodule
`default_nettype wire

// *** rtl/rxcru_event_flags.sv ***
// Purpose: sticky event flags with read-clear or write-one-clear
// Assumes: set pulses are single cycle edges found by the caller
// Notes:   a set in the clearing cycle always survives
`timescale 1ns/1ps
`default_nettype none

module rxcru_event_flags #(
    parameter int W = 3   // number of flags
) (
    input  wire logic         clock,     // system clock
    input  wire logic         sys_rst,   // synchronous reset, high
    input  wire logic [W-1:0] setPulse,  // fault entry pulses
    input  wire logic [W-1:0] w1cMask,   // bits written with one in w1c mode
    input  wire logic         rdClear,   // register read in read-clear mode
    output logic      [W-1:0] flags      // sticky flags
);
    logic [W-1:0] clrMask;    // bits to drop this cycle
    logic [W-1:0] flags_nxt;  // next flag value

    assign clrMask   = w1cMask | {W{rdClear}};
    assign flags_nxt = (flags & ~clrMask) | setPulse;  // set wins

    // flag storage
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags <= flags_nxt;
        end
    end

endmodule
`default_nettype wire

// *** rtl/rxcru_regs.sv ***
// Purpose: receive line clock-recovery and quad synthesizer control/status registers
// Assumes: 10 MHz clock, analog status inputs already synchronous, one serial bit per clock
// Notes:   analog loops sit outside; this bank configures them and reports their state
`timescale 1ns/1ps
`default_nettype none
`include "rxcru_consts.svh"

module rxcru_regs
    import rxcru_pkg::*;
(
    input  wire logic        clock,                // system clock, 10 MHz
    input  wire logic        sys_rst,              // synchronous reset, high
    input  wire logic [7:0]  regAddr,              // register address
    input  wire logic [15:0] regWrData,            // write data
    input  wire logic        regWrEn,              // write strobe
    input  wire logic        regRdEn,              // read strobe
    output logic      [15:0] regRdData,            // read data, cycle after strobe
    input  wire logic        serialRxPair,         // received serial bit
    input  wire logic        signalDetectInput,    // optical signal detect pin
    input  wire logic        refLockedIn,          // recovery loop locked to reference
    input  wire logic        freqInRangeIn,        // recovered clock within tolerance
    input  wire logic        fifoClockSelect,      // one = recovered clock for FIFO unless line loopback is on
    input  wire logic        quadModePin,          // quad-rate mode strap
    input  wire logic        synthLockedIn,        // synthesizer slave loop locked
    input  wire logic        slaveRunawayIn,       // slave loop runaway from analog
    input  wire logic        masterRunawayIn,      // master loop runaway from analog
    input  wire logic        writeOneClearMode,    // event clearing by writing one
    output logic             rxDataOut,            // polarity corrected data
    output logic             cruTrainHold,         // force recovery onto reference
    output logic             lockSourceStatus,     // one = tracking data
    output logic             losEventOut,          // loss-of-signal event
    output rxcru_fifo_clk_t  fifoTimingSrc,        // FIFO output timing source
    output logic             quadBlockRun,         // quad analog block active
    output logic             refModeSel,           // reference mode select
    output logic             refCurrentSelect,     // reference current control
    output logic             synthResetN,          // synthesizer reset, low active
    output logic             slaveRunawayDetectEn, // slave runaway detector on
    output logic             masterRunawayDetectEn,// master runaway detector on
    output logic             irqOut                // synthesizer interrupt
);

    // writable register images
    logic [15:0] trainReg_r;       // training config, status bits unused here
    logic [15:0] qGenReg_r;        // quad general control
    logic [15:0] qSynthReg_r;      // quad synthesizer control
    logic [15:0] qIrqEnReg_r;      // quad interrupt enables
    rxcru_lock_state_t lockState_r;   // lock source state
    rxcru_lock_state_t lockState_nxt; // next lock source

    // live inputs delayed for edge detection
    logic synthLockedPrev_r;       // lock state last cycle
    logic slaveLivePrev_r;         // gated slave runaway last cycle
    logic masterLivePrev_r;        // gated master runaway last cycle

    // decoded strobes
    wire wrTrain  = regWrEn && (regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS);
    wire wrQGen   = regWrEn && (regAddr == `RXCRU_OFS_QGEN);
    wire wrQSynth = regWrEn && (regAddr == `RXCRU_OFS_QSYNTH);
    wire wrQIrqEn = regWrEn && (regAddr == `RXCRU_OFS_QIRQEN);
    wire wrQEvent = regWrEn && (regAddr == `RXCRU_OFS_QEVENT);
    wire rdQEvent = regRdEn && (regAddr == `RXCRU_OFS_QEVENT);

    // named control fields
    wire [4:0] losCount     = trainReg_r[`RXCRU_LOSCNT_HI:`RXCRU_LOSCNT_LO];
    wire       losEnable    = trainReg_r[`RXCRU_LOSEN_BIT];
    wire       lineLoopback = trainReg_r[`RXCRU_LLOOP_BIT];
    wire       sigdetInvert = trainReg_r[`RXCRU_SDINV_BIT];
    wire       rxInvert     = trainReg_r[`RXCRU_RXINV_BIT];
    wire       quadDisable  = qGenReg_r[`RXCRU_QDIS_BIT];
    wire       slaveDetOff  = qIrqEnReg_r[`RXCRU_SRDIS_BIT];
    wire       masterDetOff = qIrqEnReg_r[`RXCRU_MRDIS_BIT];

    // polarity corrected line signals
    wire rxBitFixed = serialRxPair ^ rxInvert;
    wire sigDetInt  = signalDetectInput ^ sigdetInvert;

    // live status, a disabled detector reports no runaway
    wire slaveLive  = slaveRunawayIn && !slaveDetOff;
    wire masterLive = masterRunawayIn && !masterDetOff;
    wire refUnlocked  = !refLockedIn;
    wire dataUnlocked = !freqInRangeIn || losEventOut;

    // event entry pulses: lock lost, slave runaway, master runaway
    wire [2:0] evtSet = {masterLive && !masterLivePrev_r,
                         slaveLive && !slaveLivePrev_r,
                         synthLockedPrev_r && !synthLockedIn};
    wire [2:0] evtW1c = (wrQEvent && writeOneClearMode) ? regWrData[2:0] : 3'h0;
    wire       evtRdClr = rdQEvent && !writeOneClearMode;
    logic [2:0] evtFlags;          // sticky synthesizer events

    // merge written value with fixed bits through the write mask
    function automatic logic [15:0] maskWrite(input logic [15:0] old, input logic [15:0] data,
                                              input logic [15:0] wmask);
        maskWrite = (old & ~wmask) | (data & wmask);
    endfunction

    // loss-of-signal detector
    rxcru_los_detect #(
        .CNT_W (5)
    ) u_los (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .dataBit   (rxBitFixed),
        .losEnable (losEnable),
        .losCount  (losCount),
        .sigDetect (sigDetInt),
        .losEvent  (losEventOut)
    );

    // synthesizer event flags
    rxcru_event_flags #(
        .W (`RXCRU_EVT_COUNT)
    ) u_evt (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .setPulse (evtSet),
        .w1cMask  (evtW1c),
        .rdClear  (evtRdClr),
        .flags    (evtFlags)
    );

    // lock source: leave data on loss or frequency error; a lost detect acts through
    // the loss event, so the status follows the loop back onto reference a cycle later
    always_comb begin
        lockState_nxt = lockState_r;
        unique case (lockState_r)
            RXCRU_LOCK_REF: begin
                if (refLockedIn && freqInRangeIn && !losEventOut) begin
                    lockState_nxt = RXCRU_LOCK_DATA;
                end
            end
            RXCRU_LOCK_DATA: begin
                if (losEventOut || !freqInRangeIn) begin
                    lockState_nxt = RXCRU_LOCK_REF;
                end
            end
        endcase
    end

    // register writes; status bits are masked out
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trainReg_r  <= `RXCRU_LOCK_SOURCE_STATUS_RST;
            qGenReg_r   <= `RXCRU_QGEN_RST;
            qSynthReg_r <= `RXCRU_QSYNTH_RST;
            qIrqEnReg_r <= `RXCRU_QIRQEN_RST;
        end else begin
            if (wrTrain) trainReg_r <= maskWrite(trainReg_r, regWrData, `RXCRU_LOCK_SOURCE_STATUS_WMASK);
            if (wrQGen) qGenReg_r <= maskWrite(qGenReg_r, regWrData, `RXCRU_QGEN_WMASK);
            if (wrQSynth) qSynthReg_r <= maskWrite(qSynthReg_r, regWrData, `RXCRU_QSYNTH_WMASK);
            if (wrQIrqEn) qIrqEnReg_r <= maskWrite(qIrqEnReg_r, regWrData, `RXCRU_QIRQEN_WMASK);
        end
    end

    // state and edge history
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lockState_r       <= RXCRU_LOCK_REF;
            synthLockedPrev_r <= 1'b0;
            slaveLivePrev_r   <= 1'b0;
            masterLivePrev_r  <= 1'b0;
        end else begin
            lockState_r       <= lockState_nxt;
            synthLockedPrev_r <= synthLockedIn;
            slaveLivePrev_r   <= slaveLive;
            masterLivePrev_r  <= masterLive;
        end
    end

    // read mux, unmapped addresses read zero
    wire [15:0] trainRead = {trainReg_r[15:7], dataUnlocked, refUnlocked,
                             lockState_r == RXCRU_LOCK_DATA, trainReg_r[3:0]};
    wire [15:0] qIrqRead  = {6'h00, slaveLive, 4'h0, qIrqEnReg_r[4:0]};
    wire [15:0] rdMux = !regRdEn ? 16'h0000 :
                        (regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS)  ? trainRead :
                        (regAddr == `RXCRU_OFS_QGEN)   ? qGenReg_r :
                        (regAddr == `RXCRU_OFS_QSYNTH) ? qSynthReg_r :
                        (regAddr == `RXCRU_OFS_QIRQEN) ? qIrqRead :
                        (regAddr == `RXCRU_OFS_QEVENT) ? {13'h0000, evtFlags} : 16'h0000;

    // fifo timing: transmitter in loopback, else selected receive clock
    wire rxcru_fifo_clk_t fifoSel = lineLoopback ? RXCRU_FCLK_TX :
                                    fifoClockSelect ? RXCRU_FCLK_RECOV : RXCRU_FCLK_SYNTH;

    // registered outputs, all one cycle behind their sources
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regRdData             <= 16'h0000;
            rxDataOut             <= 1'b0;
            cruTrainHold          <= 1'b1;
            lockSourceStatus      <= 1'b0;
            fifoTimingSrc         <= RXCRU_FCLK_SYNTH;
            quadBlockRun          <= 1'b0;
            refModeSel            <= 1'b0;
            refCurrentSelect      <= 1'b1;
            synthResetN           <= 1'b1;
            slaveRunawayDetectEn  <= 1'b1;
            masterRunawayDetectEn <= 1'b1;
            irqOut                <= 1'b0;
        end else begin
            regRdData             <= rdMux;
            rxDataOut             <= rxBitFixed;
            cruTrainHold          <= !sigDetInt || (lockState_r == RXCRU_LOCK_REF);
            lockSourceStatus      <= lockState_r == RXCRU_LOCK_DATA;
            fifoTimingSrc         <= fifoSel;
            quadBlockRun          <= !quadDisable && quadModePin;
            refModeSel            <= qGenReg_r[`RXCRU_REFMODE_BIT];
            refCurrentSelect      <= qGenReg_r[`RXCRU_IREF_BIT];
            synthResetN           <= qSynthReg_r[`RXCRU_SRSTN_BIT];
            slaveRunawayDetectEn  <= !slaveDetOff;
            masterRunawayDetectEn <= !masterDetOff;
            irqOut                <= |(evtFlags & qIrqEnReg_r[2:0]);
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_rx_invert: assert property (!$past(sys_rst)
                                  |-> rxDataOut == ($past(serialRxPair) ^ $past(rxInvert)))
        else $error("receive data polarity wrong");
    a_lock_source_status_hold: assert property (!sigDetInt |=> cruTrainHold)
        else $error("training hold missing without signal detect");
    a_lock_source_status_read: assert property (regRdEn && regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS
                                   |=> regRdData[4] == ($past(lockState_r) == RXCRU_LOCK_DATA))
        else $error("lock source readback wrong");
    a_ref_unlock: assert property (regRdEn && regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS && !refLockedIn
                                   |=> regRdData[5])
        else $error("reference unlock not reported");
    a_data_unlock: assert property (regRdEn && regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS && losEventOut
                                    |=> regRdData[6])
        else $error("data unlock not reported on loss");
    a_los_nosd: assert property (!sigDetInt |=> losEventOut)
        else $error("loss event missing without signal detect");
    a_quad_run: assert property (!$past(sys_rst)
                                 |-> quadBlockRun == (!$past(quadDisable) && $past(quadModePin)))
        else $error("quad run enable wrong");
    a_irq_gate: assert property (!$past(sys_rst)
                                 |-> irqOut == (($past(evtFlags) & $past(qIrqEnReg_r[2:0])) != 3'h0))
        else $error("interrupt gating wrong");
    a_slave_event: assert property (slaveRunawayIn && !slaveDetOff && !slaveLivePrev_r |=> evtFlags[1])
        else $error("slave runaway event not set");
    a_loop_timing: assert property (lineLoopback |=> fifoTimingSrc == RXCRU_FCLK_TX)
        else $error("loopback timing source wrong");
    a_ro_ignored: assert property (wrTrain ##1 regRdEn && regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS
                                   |=> regRdData[5] == $past(refUnlocked))
        else $error("read-only status took a write");
    a_unused_zero: assert property (wrQGen |=> qGenReg_r[15:6] == 10'h000)
        else $error("unused general control bits took a write");

    // event flags: a read or a written one clears, a new fault always survives
    a_evt_rdclr: assert property (evtRdClr |=> evtFlags == $past(evtSet))
        else $error("read clear of events wrong");
    a_set_wins: assert property ((evtSet != 3'h0) |=> (evtFlags & $past(evtSet)) == $past(evtSet))
        else $error("event set lost against a clear");
    a_evt_w1c: assert property (writeOneClearMode && !wrQEvent
                                |=> (evtFlags & $past(evtFlags)) == $past(evtFlags))
        else $error("event dropped without a written one");
    a_master_event: assert property (masterRunawayIn && !masterDetOff && !masterLivePrev_r
                                     |=> evtFlags[2])
        else $error("master runaway event not set");

    // lock source, read-back, timing source and slave runaway detector enable
    a_lock_leave: assert property (lockState_r == RXCRU_LOCK_DATA && losEventOut
                                   |=> lockState_r == RXCRU_LOCK_REF)
        else $error("lock to data kept through a loss event");
    a_lock_status: assert property (!$past(sys_rst)
                                    |-> lockSourceStatus == ($past(lockState_r) == RXCRU_LOCK_DATA))
        else $error("lock source output wrong");
    a_freq_unlock: assert property (regRdEn && regAddr == `RXCRU_OFS_LOCK_SOURCE_STATUS && !freqInRangeIn
                                    |=> regRdData[6])
        else $error("data unlock not reported on frequency error");
    a_fifo_recov: assert property (!lineLoopback && fifoClockSelect
                                   |=> fifoTimingSrc == RXCRU_FCLK_RECOV)
        else $error("recovered clock timing source wrong");
    a_detect_en: assert property (!$past(sys_rst) |-> slaveRunawayDetectEn == !$past(slaveDetOff))
        else $error("slave runaway detector enable wrong");

    c_to_data: cover property (lockState_r == RXCRU_LOCK_REF ##1 lockState_r == RXCRU_LOCK_DATA);
    c_los_rise: cover property (!losEventOut ##1 losEventOut);
    c_irq_rise: cover property (!irqOut ##1 irqOut);
    c_evt_clear: cover property ((evtFlags != 3'h0) ##1 evtFlags == 3'h0);

endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the receive line register bank
// Assumes: 10 MHz clock, register reads answer one cycle after the strobe
// Notes:   serial data toggles every cycle unless frozen, to keep the run detector quiet
`timescale 1ns/1ps
`default_nettype none

module testbench import rxcru_pkg::*;;
    logic        clock = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic        serialRxPair = 1'b0, signalDetectInput = 1'b1, refLockedIn = 1'b1, freqInRangeIn = 1'b1;
    logic        fifoClockSelect = 1'b0, quadModePin = 1'b1, synthLockedIn = 1'b1, slaveRunawayIn = 1'b0;
    logic        masterRunawayIn = 1'b0, writeOneClearMode = 1'b0, hold = 1'b0, serPrev = 1'b0;
    logic        rxDataOut, cruTrainHold, lockSourceStatus, losEventOut, quadBlockRun, refModeSel;
    logic        refCurrentSelect, synthResetN, slaveRunawayDetectEn, masterRunawayDetectEn, irqOut;
    rxcru_fifo_clk_t fifoTimingSrc;
    int          num_errors = 0, total_checks = 0, cycles = 0;

    // clock, 100 ns period
    always #50 clock = ~clock;

    // line stimulus; serPrev mirrors the bit the design samples at each edge
    always @(posedge clock) begin
        if (!hold) serialRxPair <= ~serialRxPair;
        serPrev <= serialRxPair;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;   // hang guard
            final_report();
        end
    end

    rxcru_regs i_rxcru_regs (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .serialRxPair(serialRxPair),
        .signalDetectInput(signalDetectInput), .refLockedIn(refLockedIn), .freqInRangeIn(freqInRangeIn),
        .fifoClockSelect(fifoClockSelect), .quadModePin(quadModePin), .synthLockedIn(synthLockedIn),
        .slaveRunawayIn(slaveRunawayIn), .masterRunawayIn(masterRunawayIn),
        .writeOneClearMode(writeOneClearMode), .rxDataOut(rxDataOut), .cruTrainHold(cruTrainHold),
        .lockSourceStatus(lockSourceStatus), .losEventOut(losEventOut), .fifoTimingSrc(fifoTimingSrc),
        .quadBlockRun(quadBlockRun), .refModeSel(refModeSel), .refCurrentSelect(refCurrentSelect),
        .synthResetN(synthResetN), .slaveRunawayDetectEn(slaveRunawayDetectEn),
        .masterRunawayDetectEn(masterRunawayDetectEn), .irqOut(irqOut));

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock) begin regAddr <= a; regWrData <= d; regWrEn <= 1'b1; end
        @(posedge clock) regWrEn <= 1'b0;
    endtask

    // read strobe, data sampled in the following cycle only
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock) begin regAddr <= a; regRdEn <= 1'b1; end
        @(posedge clock) regRdEn <= 1'b0;
        #1 chk(regRdData, e);
    endtask

    // settle a number of edges, then look just after the last one
    task automatic w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        w(6);
        chk({refCurrentSelect, synthResetN, slaveRunawayDetectEn, masterRunawayDetectEn}, 16'h000F);
        rdc(8'h30, 16'h0030); rdc(8'h31, 16'h4A1F); rdc(8'h33, 16'h0000); rdc(8'h50, 16'h0000);
        rdc(8'h23, 16'h441F);
        @(posedge clock); refLockedIn <= 1'b0; freqInRangeIn <= 1'b0; w(3);
        rdc(8'h23, 16'h446F);
        @(posedge clock); refLockedIn <= 1'b1; freqInRangeIn <= 1'b1; w(3);
        // read-only live bits must not take written ones; inversion on
        wr(8'h23, 16'h44FF); w(3);
        rdc(8'h23, 16'h449F);
        chk(rxDataOut, !serPrev);
        wr(8'h23, 16'h450F); w(3);
        chk({losEventOut, cruTrainHold, lockSourceStatus}, 16'h0006);
        rdc(8'h23, 16'h454F);
        @(posedge clock); signalDetectInput <= 1'b0; w(4);
        chk({losEventOut, cruTrainHold}, 16'h0000);
        chk(rxDataOut, serPrev);
        wr(8'h23, 16'h460F); w(2);
        chk(fifoTimingSrc, RXCRU_FCLK_TX);
        @(posedge clock); fifoClockSelect <= 1'b1; wr(8'h23, 16'h440F); w(2);
        chk(fifoTimingSrc, RXCRU_FCLK_RECOV);
        // signal detect back, so only the run length can raise loss below
        @(posedge clock); fifoClockSelect <= 1'b0; signalDetectInput <= 1'b1; w(2);
        chk(fifoTimingSrc, RXCRU_FCLK_SYNTH);
        // count of one means a run of sixteen equal bits
        wr(8'h23, 16'h0C0F); hold <= 1'b1; w(12);
        chk(losEventOut, 1'b0);
        w(8);
        chk(losEventOut, 1'b1);
        wr(8'h23, 16'h080F); w(3);
        chk(losEventOut, 1'b0);
        hold <= 1'b0; wr(8'h23, 16'h440F);
        wr(8'h30, 16'h0031); w(2);
        chk(quadBlockRun, 1'b0);
        wr(8'h30, 16'hFFE4); w(2);
        chk({quadBlockRun, refModeSel, refCurrentSelect}, 16'h0006);
        rdc(8'h30, 16'h0024);
        wr(8'h31, 16'h4A1E); w(2);
        chk(synthResetN, 1'b0);
        // keep the synthesizer in reset 53 us at the faster reference, 100 ns a cycle
        w(530); wr(8'h31, 16'h4A1F); w(2);
        chk(synthResetN, 1'b1);
        wr(8'h33, 16'hFC18); w(2);
        chk({slaveRunawayDetectEn, masterRunawayDetectEn}, 16'h0000);
        rdc(8'h33, 16'h0018);
        wr(8'h33, 16'h0007); slaveRunawayIn <= 1'b1; w(4);
        chk(irqOut, 1'b1);
        rdc(8'h33, 16'h0207);
        rdc(8'h34, 16'h0002);
        rdc(8'h34, 16'h0000);
        w(2);
        chk(irqOut, 1'b0);
        wr(8'h33, 16'h0000); synthLockedIn <= 1'b0; w(4);
        chk(irqOut, 1'b0);
        @(posedge clock); writeOneClearMode <= 1'b1; masterRunawayIn <= 1'b1; w(4);
        rdc(8'h34, 16'h0005);
        rdc(8'h34, 16'h0005);
        wr(8'h34, 16'h0004);
        rdc(8'h34, 16'h0001);
        // mid-run reset brings every writable field back to its default
        @(posedge clock); sys_rst <= 1'b1; repeat (3) @(posedge clock); sys_rst <= 1'b0;
        rdc(8'h30, 16'h0030); rdc(8'h31, 16'h4A1F); rdc(8'h23, 16'h441F);
        rdc(8'h33, 16'h0200);
        final_report();
    end
endmodule

`default_nettype wire
